// [common/hirq_defs.svh]
// Constants for the host interrupt request logic: offsets, bit positions, resets.
// Assumes inclusion by bare name from the package and both ends.
// What this block does
// R1 - Buffers and interrupt registers feed interrupt logic
// R2 - Flags set regardless of enable
// R3 - Enabled condition raises request and active bit
// R4 - Four sources, each separately maskable
// R5 - New status on RAM access or status change
// R6 - Writing 0 to status flag clears active
// R7 - Config done shown by flag falling
// R8 - Writing 0 to config enable clears active
// R9 - Host sets config flag after new taps
// R10 - Empty transmit buffer raises transmit flag
// R11 - Transmit write clears flag and active
// R12 - Received byte sets receive-full flag
// R13 - Receive buffer read clears flag and active
// R14 - Host reads error status before byte; the host here reads 00 directly, with no status read first
// R15 - Request held while any active bit set
// R16 - Flags hold until their clearing action
`ifndef HIRQ_DEFS_SVH
`define HIRQ_DEFS_SVH
// ----------------------------------------
// Interface register offsets
// ----------------------------------------
`define HIRQ_OFF_RXBUF 8'h00
`define HIRQ_OFF_TXBUF 8'h10
`define HIRQ_OFF_ICLO 8'h1E
`define HIRQ_OFF_ICHI 8'h1F
// ----------------------------------------
// Bit positions in interrupt_control_low (0x1E)
// ----------------------------------------
`define HIRQ_B_RX_FLAG 0
`define HIRQ_B_RX_EN 1
`define HIRQ_B_RX_ACT 2
`define HIRQ_B_TX_FLAG 3
`define HIRQ_B_TX_EN 4
`define HIRQ_B_TX_ACT 5
// ----------------------------------------
// Bit positions in interrupt_control_high (0x1F)
// ----------------------------------------
`define HIRQ_B_NS_FLAG 0
`define HIRQ_B_NS_EN 1
`define HIRQ_B_NS_ACT 2
`define HIRQ_B_NC_FLAG 3
`define HIRQ_B_NC_EN 4
`define HIRQ_B_NC_ACT 5
// ----------------------------------------
// Controller register map on Avalon-MM (word addresses)
// ----------------------------------------
`define HIRQ_CSR_CMD 3'h0
`define HIRQ_CSR_TXDATA 3'h1
`define HIRQ_CSR_RXDATA 3'h2
`define HIRQ_CSR_STAT 3'h3
`define HIRQ_CSR_MASK 3'h4
`define HIRQ_CSR_BITS 3'h5
// Command bits
`define HIRQ_CMD_READ_RX 0
`define HIRQ_CMD_SEND_TX 1
`define HIRQ_CMD_NEW_CONFIG_FLAG 2
`define HIRQ_CMD_CLR_NS 3
`define HIRQ_CMD_CLR_NC 4
`define HIRQ_CMD_EN_LO 8
`define HIRQ_CMD_EN_HI 11
// Reset values
`define HIRQ_RST_BYTE 8'h00
`define HIRQ_RST_EV 4'h0
`endif

// [common/hirq_if.sv]
// Parallel register port between host controller and modem interface.
// Assumes one clock and synchronous single-cycle accesses.
`timescale 1ns/1ps
interface hirq_if;
	logic [7:0] addr;
	logic wr;
	logic rd;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic irq;
	modport device (input addr, input wr, input rd, input wdata, output rdata, output irq);
	modport host (output addr, output wr, output rd, output wdata, input rdata, input irq);
endinterface

// [common/hirq_pkg.sv]
// Types shared by both ends of the host interrupt request logic.
// Assumes hirq_defs.svh is on the include path.
`include "hirq_defs.svh"
package hirq_pkg;
	// Source index: 0 rx full, 1 tx empty, 2 new status, 3 new config
	typedef logic [3:0] hirq_src_t;
	typedef enum logic [1:0] {HIRQ_IDLE, HIRQ_WAIT, HIRQ_DONE} hirq_acc_t;
endpackage

// [hw/hirq_device.sv]
// Modem end: interface memory registers 00, 10, 1E, 1F and the request line.
// Assumes host accesses last one cycle; DSP-side events are one-cycle pulses.
`timescale 1ns/1ps
`include "hirq_defs.svh"
module hirq_device import hirq_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	hirq_if.device bus,
	input wire logic rx_byte_valid,
	input wire logic [7:0] rx_byte,
	input wire logic tx_room,
	input wire logic ram_access_done,
	input wire logic status_changed,
	input wire logic config_applied,
	output logic [7:0] tx_byte,
	output logic tx_byte_valid,
	output logic new_config_req
);
	typedef struct packed {
		logic [7:0] rxbuf;
		logic [7:0] txbuf;
		logic txv;
		logic [7:0] rdata;
		hirq_src_t flag;
		hirq_src_t en;
		hirq_src_t act;
		logic irq;
		logic tx_room_d;
	} hirq_dev_t;
	hirq_dev_t st_ff;
	hirq_dev_t nxt_st;
	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		hirq_src_t ev;
		logic wlo;
		logic whi;
		ev = `HIRQ_RST_EV;
		nxt_st = st_ff;
		nxt_st.txv = 1'b0;
		wlo = bus.wr && bus.addr == `HIRQ_OFF_ICLO;
		whi = bus.wr && bus.addr == `HIRQ_OFF_ICHI;
		// Enables and the host-owned new-config flag
		if (wlo) begin
			nxt_st.en[0] = bus.wdata[`HIRQ_B_RX_EN];
			nxt_st.en[1] = bus.wdata[`HIRQ_B_TX_EN];
		end
		if (whi) begin
			nxt_st.en[2] = bus.wdata[`HIRQ_B_NS_EN];
			nxt_st.en[3] = bus.wdata[`HIRQ_B_NC_EN];
			if (bus.wdata[`HIRQ_B_NC_FLAG]) begin
				nxt_st.flag[3] = 1'b1; // [R9]
			end
		end
		// Clearing actions [R16]
		if (bus.rd && bus.addr == `HIRQ_OFF_RXBUF) begin
			nxt_st.flag[0] = 1'b0; // [R13]
			nxt_st.act[0] = 1'b0;
		end
		if (bus.wr && bus.addr == `HIRQ_OFF_TXBUF) begin
			nxt_st.txbuf = bus.wdata; // [R1]
			nxt_st.txv = 1'b1;
			nxt_st.flag[1] = 1'b0; // [R11]
			nxt_st.act[1] = 1'b0;
		end
		if (whi && !bus.wdata[`HIRQ_B_NS_FLAG]) begin
			nxt_st.flag[2] = 1'b0; // [R6]
			nxt_st.act[2] = 1'b0;
		end
		if (whi && !bus.wdata[`HIRQ_B_NC_EN]) begin
			nxt_st.act[3] = 1'b0; // [R8]
		end
		// Conditions; a set wins over a same-cycle clear, except that config done clears flag 3 over a host set
		nxt_st.tx_room_d = tx_room;
		if (rx_byte_valid) begin
			nxt_st.rxbuf = rx_byte;
			ev[0] = 1'b1; // [R12]
		end
		ev[1] = tx_room && !st_ff.tx_room_d; // [R10]
		ev[2] = ram_access_done || status_changed; // [R5]
		ev[3] = config_applied && st_ff.flag[3]; // [R7]
		for (int i = 0; i < 3; i++) begin
			if (ev[i]) begin
				nxt_st.flag[i] = 1'b1; // [R2]
			end
		end
		if (ev[3]) begin
			nxt_st.flag[3] = 1'b0;
		end
		nxt_st.act = nxt_st.act | (ev & nxt_st.en); // [R3] [R4]
		nxt_st.irq = |nxt_st.act; // [R15]
		// Read data
		unique case (bus.addr)
			`HIRQ_OFF_RXBUF: nxt_st.rdata = st_ff.rxbuf;
			`HIRQ_OFF_ICLO: nxt_st.rdata = {2'h0, st_ff.act[1], st_ff.en[1], st_ff.flag[1],
				st_ff.act[0], st_ff.en[0], st_ff.flag[0]};
			`HIRQ_OFF_ICHI: nxt_st.rdata = {2'h0, st_ff.act[3], st_ff.en[3], st_ff.flag[3],
				st_ff.act[2], st_ff.en[2], st_ff.flag[2]};
			default: nxt_st.rdata = `HIRQ_RST_BYTE;
		endcase
	end
	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
	assign bus.rdata = st_ff.rdata;
	assign bus.irq = st_ff.irq;
	assign tx_byte = st_ff.txbuf;
	assign tx_byte_valid = st_ff.txv;
	assign new_config_req = st_ff.flag[3];
endmodule

// [hw/hirq_host.sv]
// Host controller end: Avalon-MM slave registers drive accesses to the modem.
// Assumes modem answers read data one cycle after the read strobe.
`timescale 1ns/1ps
`include "hirq_defs.svh"
module hirq_host import hirq_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	hirq_if.host link,
	input wire logic [2:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic irq_out
);
	typedef struct packed {
		hirq_acc_t acc;
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
		logic [7:0] rxdata;
		logic [7:0] bits;
		hirq_src_t en;
		logic [3:0] stat;
		logic [3:0] mask;
		logic [31:0] rdata;
		logic wait_n;
		logic irq;
		logic irq_d;
		logic rx_pend;
	} hirq_host_t;
	hirq_host_t st_ff;
	hirq_host_t nxt_st;
	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic [3:0] ev;
		nxt_st = st_ff;
		ev = 4'h0;
		nxt_st.wr = 1'b0;
		nxt_st.rd = 1'b0;
		nxt_st.wait_n = 1'b0;
		nxt_st.irq_d = link.irq;
		// Events: rx byte read, tx byte sent, link request rising
		unique case (st_ff.acc)
			HIRQ_IDLE: begin
				if (avs_write && !st_ff.wait_n) begin
					nxt_st.wait_n = 1'b1;
					unique case (avs_address)
						`HIRQ_CSR_TXDATA: nxt_st.wdata = avs_writedata[7:0];
						`HIRQ_CSR_STAT: nxt_st.stat = st_ff.stat & ~avs_writedata[3:0];
						`HIRQ_CSR_MASK: nxt_st.mask = avs_writedata[3:0];
						`HIRQ_CSR_CMD: begin
							nxt_st.en = avs_writedata[`HIRQ_CMD_EN_HI:`HIRQ_CMD_EN_LO];
							nxt_st.wait_n = 1'b0;
							nxt_st.acc = HIRQ_WAIT;
							nxt_st.wr = 1'b1;
							nxt_st.addr = `HIRQ_OFF_ICHI;
							nxt_st.wdata = {2'h0, 1'b0,
								avs_writedata[`HIRQ_CMD_EN_HI] & ~avs_writedata[`HIRQ_CMD_CLR_NC],
								avs_writedata[`HIRQ_CMD_NEW_CONFIG_FLAG], 1'b0,
								avs_writedata[`HIRQ_CMD_EN_LO + 2],
								~avs_writedata[`HIRQ_CMD_CLR_NS]}; // [R6] [R8] [R9]
							if (avs_writedata[`HIRQ_CMD_SEND_TX]) begin
								nxt_st.addr = `HIRQ_OFF_TXBUF; // [R11]
								nxt_st.wdata = st_ff.wdata;
							end else if (avs_writedata[`HIRQ_CMD_READ_RX]) begin
								nxt_st.wr = 1'b0;
								nxt_st.rd = 1'b1; // [R13]; no error status read precedes this byte read (R14)
								nxt_st.rx_pend = 1'b1;
								nxt_st.addr = `HIRQ_OFF_RXBUF;
							end
						end
						default: ;
					endcase
				end else if (avs_read && !st_ff.wait_n) begin
					nxt_st.wait_n = 1'b1;
					unique case (avs_address)
						`HIRQ_CSR_RXDATA: nxt_st.rdata = {24'h0, st_ff.rxdata};
						`HIRQ_CSR_STAT: nxt_st.rdata = {28'h0, st_ff.stat};
						`HIRQ_CSR_MASK: nxt_st.rdata = {28'h0, st_ff.mask};
						`HIRQ_CSR_BITS: nxt_st.rdata = {24'h0, st_ff.bits};
						`HIRQ_CSR_CMD: nxt_st.rdata = {20'h0, st_ff.en, 8'h0};
						default: nxt_st.rdata = 32'h0;
					endcase
				end
			end
			HIRQ_WAIT: begin
				// Rest on the low control register; the accessed byte is already launched
				nxt_st.acc = HIRQ_DONE;
				nxt_st.addr = `HIRQ_OFF_ICLO;
			end
			HIRQ_DONE: begin
				// Remembered flag, since the link address has moved on by now
				if (st_ff.rx_pend) begin
					nxt_st.rxdata = link.rdata;
					ev[0] = 1'b1;
				end
				nxt_st.rx_pend = 1'b0;
				nxt_st.bits = link.rdata;
				nxt_st.acc = HIRQ_IDLE;
				nxt_st.wait_n = 1'b1;
			end
			default: nxt_st.acc = HIRQ_IDLE;
		endcase
		ev[1] = st_ff.acc == HIRQ_WAIT && st_ff.addr == `HIRQ_OFF_TXBUF;
		ev[2] = link.irq && !st_ff.irq_d;
		nxt_st.stat = nxt_st.stat | ev[3:0]; // set wins over clear
		nxt_st.irq = |(nxt_st.stat & nxt_st.mask);
	end
	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
	assign link.addr = st_ff.addr;
	assign link.wr = st_ff.wr;
	assign link.rd = st_ff.rd;
	assign link.wdata = st_ff.wdata;
	assign avs_readdata = st_ff.rdata;
	assign avs_waitrequest = !st_ff.wait_n;
	assign irq_out = st_ff.irq;
endmodule

// [verif/hirq_props.sv]
// Link checker: watches the register port between host and modem ends.
// Assumes the link signals are handed in by name from the bench.
`timescale 1ns/1ps
`include "hirq_defs.svh"
module hirq_props (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] addr,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// --------------------------------
	// Control register reads and link strobes
	// --------------------------------
	// Read data follows the address one cycle later, strobe or not
	wire rlo = addr == `HIRQ_OFF_ICLO;
	wire rhi = addr == `HIRQ_OFF_ICHI;
	chk_rx_act_flag: assert property (rlo |=> !rdata[2] || rdata[0])
		else $error("rx active without flag");
	chk_tx_act_flag: assert property (rlo |=> !rdata[5] || rdata[3])
		else $error("tx active without flag");
	chk_ns_act_flag: assert property (rhi |=> !rdata[2] || rdata[0])
		else $error("status active without flag");
	chk_act_to_irq: assert property ((rlo || rhi) ##1 (rdata[2] || rdata[5]) |-> $past(irq))
		else $error("active bit without request");
	chk_hi_unused: assert property (rhi |=> rdata[7:6] == 2'h0)
		else $error("unused bits set");
	chk_rd_wr_excl: assert property (!(rd && wr))
		else $error("read and write together");
	chk_wr_pulse: assert property (wr |=> !wr)
		else $error("write strobe too long");
	chk_rd_pulse: assert property (rd |=> !rd)
		else $error("read strobe too long");
endmodule

// [verif/host_interrupt_request_logic_tb.sv]
// Bench: host controller and modem end joined by the link, driven over Avalon.
// Assumes design, interface and checker are compiled first.
`timescale 1ns/1ps
`include "hirq_defs.svh"
module host_interrupt_request_logic_tb;
	import hirq_pkg::*;
	logic clk, irq_out, wreq, txv, ncr;
	logic rst_n = 1'h0, av_rd = 1'h0, av_wr = 1'h0, tx_room = 1'h0;
	logic [2:0] av_a = 3'h0;
	logic [31:0] av_d = 32'h0, av_q, q;
	logic [3:0] ev = 4'h0;
	logic [7:0] rxb = 8'hA5, txb, seen = 8'h0;
	int n_mismatch = 0, tests_run = 0, cyc = 0;
	hirq_if lnk();
	hirq_device u_hirq_device (.clk(clk), .rst_n(rst_n), .bus(lnk), .rx_byte_valid(ev[0]),
		.rx_byte(rxb), .tx_room(tx_room), .ram_access_done(ev[1]), .status_changed(ev[2]),
		.config_applied(ev[3]), .tx_byte(txb), .tx_byte_valid(txv), .new_config_req(ncr));
	hirq_host u_hirq_host (.clk(clk), .rst_n(rst_n), .link(lnk), .avs_address(av_a),
		.avs_read(av_rd), .avs_write(av_wr), .avs_writedata(av_d), .avs_readdata(av_q),
		.avs_waitrequest(wreq), .irq_out(irq_out));
	hirq_props u_hirq_props (.clk(clk), .rst_n(rst_n), .addr(lnk.addr), .wr(lnk.wr),
		.rd(lnk.rd), .rdata(lnk.rdata), .irq(lnk.irq));
	// --------------------------------
	// Clock, cycle ceiling, sent byte capture
	// --------------------------------
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (txv === 1'h1) seen <= txb;
		if (cyc == 20000) begin
			n_mismatch++;
			complete_run();
		end
	end
	// --------------------------------
	// Tasks
	// --------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One Avalon access, held until waitrequest is sampled low
	task av(input logic w, input logic [2:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		av_a <= a;
		av_wr <= w;
		av_rd <= !w;
		av_d <= d;
		for (k = 0; k < 50; k++) begin
			@(posedge clk);
			if (wreq === 1'h0) break;
		end
		q = av_q;
		av_wr <= 1'h0;
		av_rd <= 1'h0;
		if (k >= 50) chk(32'h0, 32'h1);
	endtask
	task pulse(input logic [3:0] m);
		@(posedge clk);
		ev <= m;
		@(posedge clk);
		ev <= 4'h0;
	endtask
	// Bounded wait for the link request to reach a level
	task wirq(input logic v);
		int k;
		for (k = 0; k < 20 && lnk.irq !== v; k++) @(posedge clk);
		chk(lnk.irq, v);
	endtask
	task complete_run();
		$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// --------------------------------
	// Main sequence
	// --------------------------------
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'h1;
		av(0, `HIRQ_CSR_STAT, 32'h0);
		chk(q, 32'h0);
		av(0, 3'h6, 32'h0);
		chk(q, 32'h0);
		av(1, `HIRQ_CSR_MASK, 32'h7);
		pulse(4'h1);
		av(1, `HIRQ_CSR_CMD, 32'h1);
		av(0, `HIRQ_CSR_RXDATA, 32'h0);
		chk(q, 32'hA5);
		av(0, `HIRQ_CSR_STAT, 32'h0);
		chk(q & 32'h1, 32'h1);
		tx_room <= 1'h1;
		av(1, `HIRQ_CSR_TXDATA, 32'h3C);
		av(1, `HIRQ_CSR_CMD, 32'h2);
		repeat (3) @(posedge clk);
		chk(seen, 8'h3C);
		av(1, `HIRQ_CSR_CMD, 32'hF00);
		pulse(4'h4);
		wirq(1'h1);
		av(0, `HIRQ_CSR_STAT, 32'h0);
		chk(q & 32'h4, 32'h4);
		chk(irq_out, 1'h1);
		av(1, `HIRQ_CSR_CMD, 32'hF08);
		wirq(1'h0);
		av(1, `HIRQ_CSR_STAT, 32'h7);
		repeat (2) @(posedge clk);
		chk(irq_out, 1'h0);
		pulse(4'h2);
		wirq(1'h1);
		av(1, `HIRQ_CSR_CMD, 32'hF08);
		wirq(1'h0);
		av(1, `HIRQ_CSR_CMD, 32'h0);
		pulse(4'h4);
		repeat (5) @(posedge clk);
		chk(lnk.irq, 1'h0);
		av(1, `HIRQ_CSR_CMD, 32'h8);
		av(0, `HIRQ_CSR_BITS, 32'h0);
		chk(q, 32'h1);
		av(1, `HIRQ_CSR_CMD, 32'hF04);
		chk(ncr, 1'h1);
		pulse(4'h8);
		wirq(1'h1);
		chk(ncr, 1'h0);
		av(1, `HIRQ_CSR_CMD, 32'h710);
		wirq(1'h0);
		complete_run();
	end
endmodule
